// ==== capture_steer_defines.vh ====
// Register map, field positions and reset values of the capture and
// pulse steering block. Included by every design file of the block.
`ifndef CAPTURE_STEER_DEFINES_VH
`define CAPTURE_STEER_DEFINES_VH

// Register indices; byte address is four times the index
`define IDX_STEER_3 12'hf1a
`define IDX_STEER_2 12'hfb9
`define IDX_STEER_1 12'hfbf
`define IDX_CTRL_1 12'h100
`define IDX_CTRL_2 12'h101
`define IDX_CTRL_3 12'h102
`define IDX_TSEL 12'h103
`define IDX_STATUS 12'h104
`define IDX_MASK 12'h105
`define IDX_CAP_1 12'h108
`define IDX_CAP_2 12'h109
`define IDX_CAP_3 12'h10a

// Unit control register fields
`define CTRL_MODE_LSB 0
`define CTRL_PXM_LSB 6
`define CTRL_WMASK 8'hcf
`define CTRL_RESET 8'h00

// Mode encodings
`define MODE_OFF 4'h0
`define MODE_CAP_FALL 4'h4
`define MODE_CAP_RISE 4'h5
`define MODE_CAP_R4 4'h6
`define MODE_CAP_R16 4'h7
`define MODE_HI_CAPTURE 2'h1
`define MODE_HI_PWM 2'h3
`define PXM_SINGLE 2'h0

// Steering register fields
`define STEER_COMPLEMENTARY_ASSIGN_LSB 6
`define STEER_SYNC_BIT 4
`define STEER_WMASK 8'hdf
`define STEER_RESET 8'h01

// Prescaler divisions
`define PRE_DIV_4 4'h3
`define PRE_DIV_16 4'hf

`endif

// ==== capture_prescaler.v ====
// Edge detector and event prescaler for one capture channel.
// Assumes i_level is already synchronised to i_clk.
`timescale 1ns/1ns
`include "capture_steer_defines.vh"

module capture_prescaler (
  input wire i_clk,
  input wire i_rst,
  input wire i_en,
  input wire i_level,
  input wire [3:0] i_mode,
  output reg o_capture,
  output reg o_swap
);

reg level_q;
reg [3:0] cnt_q;
reg [3:0] mode_q;
wire cap_mode = (i_mode[3:2] == `MODE_HI_CAPTURE);
wire was_cap = (mode_q[3:2] == `MODE_HI_CAPTURE);
wire rise = i_level & ~level_q;
wire fall = ~i_level & level_q;
wire event_hit = (i_mode == `MODE_CAP_FALL) ? fall : rise;
reg [3:0] last;

always @* begin
  case (i_mode)
    `MODE_CAP_R4: last = `PRE_DIV_4;
    `MODE_CAP_R16: last = `PRE_DIV_16;
    default: last = 4'h0;
  endcase
end

always @(posedge i_clk or posedge i_rst) begin
  if (i_rst) begin
    level_q <= 1'b0;
    cnt_q <= 4'h0;
    mode_q <= 4'h0;
    o_capture <= 1'b0;
    o_swap <= 1'b0;
  end else if (i_en) begin
    level_q <= i_level;
    mode_q <= i_mode;
    o_capture <= 1'b0;
    o_swap <= cap_mode & was_cap & (i_mode != mode_q);
    if (!cap_mode) begin
      cnt_q <= 4'h0;
    end else if (event_hit) begin
      if (cnt_q >= last) begin
        cnt_q <= 4'h0;
        o_capture <= 1'b1;
      end else begin
        cnt_q <= cnt_q + 4'h1;
      end
    end
  end
end

endmodule

// ==== pulse_steer.v ====
// Output steering for one unit: drives pins A to D from the PWM wave.
// Assumes wave, period end and instruction tick come from i_clk logic.
`timescale 1ns/1ns
`include "capture_steer_defines.vh"

module pulse_steer (
  input wire i_clk,
  input wire i_rst,
  input wire i_en,
  input wire [7:0] i_steer,
  input wire [3:0] i_mode,
  input wire [1:0] i_pxm,
  input wire i_wave,
  input wire i_period_end,
  input wire i_instr_tick,
  input wire [3:0] i_port_out,
  input wire [3:0] i_port_oe,
  output reg [3:0] o_pin_out,
  output reg [3:0] o_pin_oe
);

reg [7:0] act_q;
reg alt_q;
wire complementary_assign = |act_q[`STEER_COMPLEMENTARY_ASSIGN_LSB+1:`STEER_COMPLEMENTARY_ASSIGN_LSB];
wire sync = i_steer[`STEER_SYNC_BIT];
wire active = (i_mode[3:2] == `MODE_HI_PWM) & (i_pxm == `PXM_SINGLE);
wire [3:0] inv = {i_mode[0], i_mode[1], i_mode[0], i_mode[1]};
wire [3:0] pins = complementary_assign ? {2'b00, alt_q, ~alt_q} : act_q[3:0];
wire [3:0] steer_on = pins & {4{active}};

always @(posedge i_clk or posedge i_rst) begin
  if (i_rst) begin
    act_q <= `STEER_RESET;
    alt_q <= 1'b0;
    o_pin_out <= 4'h0;
    o_pin_oe <= 4'h0;
  end else if (i_en) begin
    if (sync ? i_period_end : i_instr_tick) begin
      act_q <= i_steer;
    end
    if (!complementary_assign) begin
      alt_q <= 1'b0;
    end else if (i_period_end) begin
      alt_q <= ~alt_q;
    end
    o_pin_out <= (steer_on & ({4{i_wave}} ^ inv)) | (~steer_on & i_port_out);
    o_pin_oe <= steer_on | (~steer_on & i_port_oe);
  end
end

endmodule

// ==== capture_steer_top.v ====
// Capture timebase select, capture prescaler and pulse steering for
// three units, with an Avalon-MM register slave and one interrupt.
// Assumes timers, PWM waves and period strobes come from I_REF_CLK
// logic; the capture pins are asynchronous.
`timescale 1ns/1ns
`include "capture_steer_defines.vh"

module capture_steer_top #(
  parameter UNITS = 3,
  parameter TMR_W = 16
) (
  input wire I_REF_CLK,
  input wire I_RST,
  input wire I_CLK_EN,
  input wire [13:0] I_AVS_ADDRESS,
  input wire I_AVS_READ,
  input wire I_AVS_WRITE,
  input wire [31:0] I_AVS_WRITEDATA,
  input wire [3:0] I_AVS_BYTEENABLE,
  output reg [31:0] O_AVS_READDATA,
  output reg O_AVS_WAITREQUEST,
  output reg O_IRQ,
  input wire [UNITS-1:0] I_CAPTURE_PIN,
  input wire [TMR_W-1:0] I_TIMER_A,
  input wire [TMR_W-1:0] I_TIMER_B,
  input wire [UNITS-1:0] I_PWM_WAVE,
  input wire [UNITS-1:0] I_PERIOD_END,
  input wire I_INSTR_TICK,
  input wire [4*UNITS-1:0] I_PORT_OUT,
  input wire [4*UNITS-1:0] I_PORT_OE,
  output wire [4*UNITS-1:0] O_PIN_OUT,
  output wire [4*UNITS-1:0] O_PIN_OE
);

////////////////////////////////////////////////////////////////////////
// Decoding

// One-hot unit owning a steering index
function [2:0] steer_hit;
  input [11:0] idx;
  begin
    steer_hit = {idx == `IDX_STEER_3,
                 idx == `IDX_STEER_2,
                 idx == `IDX_STEER_1};
  end
endfunction

// One-hot unit owning a control index
function [2:0] ctrl_hit;
  input [11:0] idx;
  begin
    ctrl_hit = {idx == `IDX_CTRL_3,
                idx == `IDX_CTRL_2,
                idx == `IDX_CTRL_1};
  end
endfunction

// One-hot unit owning a capture value index
function [2:0] cap_hit;
  input [11:0] idx;
  begin
    cap_hit = {idx == `IDX_CAP_3,
               idx == `IDX_CAP_2,
               idx == `IDX_CAP_1};
  end
endfunction

// One-hot shared register: {mask, status, timer select}
function [2:0] shared_hit;
  input [11:0] idx;
  begin
    shared_hit = {idx == `IDX_MASK,
                  idx == `IDX_STATUS,
                  idx == `IDX_TSEL};
  end
endfunction

////////////////////////////////////////////////////////////////////////
// Bus handshake

wire req = I_AVS_READ | I_AVS_WRITE;
wire [11:0] idx = I_AVS_ADDRESS[13:2];
wire aligned = (I_AVS_ADDRESS[1:0] == 2'b00);
wire accept = req & ~O_AVS_WAITREQUEST;
wire wr_acc = accept & I_AVS_WRITE & aligned & I_AVS_BYTEENABLE[0];
wire rd_acc = accept & I_AVS_READ & aligned;
wire [7:0] wbyte = I_AVS_WRITEDATA[7:0];

reg [8*UNITS-1:0] ctrl_q;
reg [8*UNITS-1:0] steer_q;
reg [UNITS-1:0] tsel_q;
reg [UNITS-1:0] status_q;
reg [UNITS-1:0] mask_q;
reg [UNITS-1:0] stat_seen_q;
reg [TMR_W*UNITS-1:0] cap_q;
reg [31:0] rd_d;
reg [UNITS-1:0] cap_sync1_q;
reg [UNITS-1:0] cap_sync2_q;
wire [UNITS-1:0] cap_pulse;
wire [UNITS-1:0] swap_pulse;
wire [2:0] steer_sel = steer_hit(idx);
wire [2:0] ctrl_sel = ctrl_hit(idx);
wire [2:0] cap_sel = cap_hit(idx);
wire [2:0] shared_sel = shared_hit(idx);

// A status read seen before its answer, and one answered now
wire stat_open = O_AVS_WAITREQUEST & I_AVS_READ & aligned & shared_sel[1];
wire stat_done = rd_acc & shared_sel[1];

// Write strobes of the shared registers
wire tsel_we = I_CLK_EN & wr_acc & shared_sel[0];
wire mask_we = I_CLK_EN & wr_acc & shared_sel[2];

// Bus answer as a one-hot state: idle, then one answer cycle
localparam ST_IDLE = 2'b01;
localparam ST_ANSWER = 2'b10;

reg [1:0] bus_q;
reg [1:0] bus_d;

always @* begin
  bus_d = bus_q;
  case (bus_q)
    ST_IDLE: begin
      if (req) begin
        bus_d = ST_ANSWER;
      end
    end
    ST_ANSWER: begin
      bus_d = ST_IDLE;
    end
    default: begin
      bus_d = ST_IDLE;
    end
  endcase
end

// Waitrequest follows the next state so it leaves a flop directly
always @(posedge I_REF_CLK or posedge I_RST) begin
  if (I_RST) begin
    bus_q <= ST_IDLE;
    O_AVS_WAITREQUEST <= 1'b1;
    O_AVS_READDATA <= 32'h0000_0000;
  end else if (I_CLK_EN) begin
    bus_q <= bus_d;
    O_AVS_WAITREQUEST <= ~bus_d[1];
    // Read data stand until the next read answer
    if (bus_d[1] && I_AVS_READ) begin
      O_AVS_READDATA <= rd_d;
    end
  end
end

////////////////////////////////////////////////////////////////////////
// Read mux

integer k;
always @* begin
  rd_d = 32'h0000_0000;
  if (aligned) begin
    for (k = 0; k < UNITS; k = k + 1) begin
      if (steer_sel[k]) begin
        rd_d[7:0] = steer_q[8*k +: 8] & `STEER_WMASK;
      end
      if (ctrl_sel[k]) begin
        rd_d[7:0] = ctrl_q[8*k +: 8] & `CTRL_WMASK;
      end
      if (cap_sel[k]) begin
        rd_d[TMR_W-1:0] = cap_q[TMR_W*k +: TMR_W];
      end
    end
    if (shared_sel[0]) begin
      rd_d[UNITS-1:0] = tsel_q;
    end
    if (shared_sel[1]) begin
      rd_d[UNITS-1:0] = status_q;
    end
    if (shared_sel[2]) begin
      rd_d[UNITS-1:0] = mask_q;
    end
  end
end

////////////////////////////////////////////////////////////////////////
// Shared registers

// Timer select and interrupt mask, written through byte zero
always @(posedge I_REF_CLK or posedge I_RST) begin
  if (I_RST) begin
    tsel_q <= {UNITS{1'b0}};
  end else if (tsel_we) begin
    tsel_q <= wbyte[UNITS-1:0];
  end
end

always @(posedge I_REF_CLK or posedge I_RST) begin
  if (I_RST) begin
    mask_q <= {UNITS{1'b0}};
  end else if (mask_we) begin
    mask_q <= wbyte[UNITS-1:0];
  end
end

////////////////////////////////////////////////////////////////////////
// Status and interrupt

// Status bits shown at the read's first cycle are the ones cleared
always @(posedge I_REF_CLK or posedge I_RST) begin
  if (I_RST) begin
    stat_seen_q <= {UNITS{1'b0}};
  end else if (I_CLK_EN) begin
    if (stat_open) begin
      stat_seen_q <= status_q;
    end
  end
end

// Capture and prescaler-swap events set flags
wire [UNITS-1:0] stat_set = cap_pulse | swap_pulse;
wire [UNITS-1:0] stat_clr = stat_done ? stat_seen_q : {UNITS{1'b0}};

// A new event wins over a clear in the same cycle
always @(posedge I_REF_CLK or posedge I_RST) begin
  if (I_RST) begin
    status_q <= {UNITS{1'b0}};
  end else if (I_CLK_EN) begin
    status_q <= (status_q & ~stat_clr) | stat_set;
  end
end

wire irq_d = |(status_q & mask_q);

always @(posedge I_REF_CLK or posedge I_RST) begin
  if (I_RST) begin
    O_IRQ <= 1'b0;
  end else if (I_CLK_EN) begin
    O_IRQ <= irq_d;
  end
end

////////////////////////////////////////////////////////////////////////
// Capture input sync

// Capture pins are asynchronous: two flops per pin before any logic
genvar s;
generate
  for (s = 0; s < UNITS; s = s + 1) begin : g_sync
    always @(posedge I_REF_CLK or posedge I_RST) begin
      if (I_RST) begin
        cap_sync1_q[s] <= 1'b0;
        cap_sync2_q[s] <= 1'b0;
      end else if (I_CLK_EN) begin
        cap_sync1_q[s] <= I_CAPTURE_PIN[s];
        cap_sync2_q[s] <= cap_sync1_q[s];
      end
    end
  end
endgenerate

////////////////////////////////////////////////////////////////////////
// Per-unit logic

genvar u;
generate
  for (u = 0; u < UNITS; u = u + 1) begin : g_unit
    wire [3:0] mode = ctrl_q[8*u + `CTRL_MODE_LSB +: 4];
    wire [1:0] output_config_field = ctrl_q[8*u + `CTRL_PXM_LSB +: 2];
    wire ctrl_we = I_CLK_EN & wr_acc & ctrl_sel[u];
    wire steer_we = I_CLK_EN & wr_acc & steer_sel[u];
    wire [TMR_W-1:0] tbase = tsel_q[u] ? I_TIMER_B : I_TIMER_A;

    always @(posedge I_REF_CLK or posedge I_RST) begin
      if (I_RST) begin
        ctrl_q[8*u +: 8] <= `CTRL_RESET;
      end else if (ctrl_we) begin
        ctrl_q[8*u +: 8] <= wbyte & `CTRL_WMASK;
      end
    end

    always @(posedge I_REF_CLK or posedge I_RST) begin
      if (I_RST) begin
        steer_q[8*u +: 8] <= `STEER_RESET;
      end else if (steer_we) begin
        steer_q[8*u +: 8] <= wbyte & `STEER_WMASK;
      end
    end

    always @(posedge I_REF_CLK or posedge I_RST) begin
      if (I_RST) begin
        cap_q[TMR_W*u +: TMR_W] <= {TMR_W{1'b0}};
      end else if (I_CLK_EN && cap_pulse[u]) begin
        cap_q[TMR_W*u +: TMR_W] <= tbase;
      end
    end

    capture_prescaler u_pre (
      .i_clk(I_REF_CLK),
      .i_rst(I_RST),
      .i_en(I_CLK_EN),
      .i_level(cap_sync2_q[u]),
      .i_mode(mode),
      .o_capture(cap_pulse[u]),
      .o_swap(swap_pulse[u])
    );

    pulse_steer u_steer (
      .i_clk(I_REF_CLK),
      .i_rst(I_RST),
      .i_en(I_CLK_EN),
      .i_steer(steer_q[8*u +: 8]),
      .i_mode(mode),
      .i_pxm(output_config_field),
      .i_wave(I_PWM_WAVE[u]),
      .i_period_end(I_PERIOD_END[u]),
      .i_instr_tick(I_INSTR_TICK),
      .i_port_out(I_PORT_OUT[4*u +: 4]),
      .i_port_oe(I_PORT_OE[4*u +: 4]),
      .o_pin_out(O_PIN_OUT[4*u +: 4]),
      .o_pin_oe(O_PIN_OE[4*u +: 4])
    );
  end
endgenerate

endmodule

// ==== capture_steer_properties.sv ====
// Port checker for capture_steer_top: bus answer, interrupt and pins.
// Assumes it is bound to the top module with I_CLK_EN held high.
`timescale 1ns/1ns
module capture_steer_properties #(
  parameter UNITS = 3
) (
  input wire I_REF_CLK,
  input wire I_RST,
  input wire I_CLK_EN,
  input wire I_AVS_READ,
  input wire I_AVS_WRITE,
  input wire [31:0] O_AVS_READDATA,
  input wire O_AVS_WAITREQUEST,
  input wire O_IRQ,
  input wire [UNITS-1:0] I_CAPTURE_PIN,
  input wire [4*UNITS-1:0] I_PORT_OUT,
  input wire [4*UNITS-1:0] I_PORT_OE,
  input wire [4*UNITS-1:0] O_PIN_OUT,
  input wire [4*UNITS-1:0] O_PIN_OE
);
  reg [UNITS-1:0] pin_q;
  reg [3:0] age_q;
  wire ack = !O_AVS_WAITREQUEST;
  wire req_open = (I_AVS_READ || I_AVS_WRITE) && O_AVS_WAITREQUEST &&
    I_CLK_EN;
  default clocking cb @(posedge I_REF_CLK); endclocking
  default disable iff (I_RST);
  ////////////////////////////////////////////////////////////////////
  // Cycles since a capture pin last moved
  always @(posedge I_REF_CLK or posedge I_RST) begin
    if (I_RST) begin
      pin_q <= {UNITS{1'b0}};
      age_q <= 4'hf;
    end else begin
      pin_q <= I_CAPTURE_PIN;
      age_q <= (pin_q != I_CAPTURE_PIN) ? 4'h0 :
        age_q + {3'h0, age_q != 4'hf};
    end
  end
  sequence s_req;
    req_open;
  endsequence
  sequence s_answer;
    ack ##1 !ack;
  endsequence
  ////////////////////////////////////////////////////////////////////
  AST_ACK_NEXT: assert property (s_req |=> s_answer)
    else $error("request not answered in one cycle");
  AST_ACK_CAUSE: assert property (ack |-> $past(req_open))
    else $error("answer without request");
  AST_RDATA_HOLD: assert property
    (!$stable(O_AVS_READDATA) |-> ack && $past(I_AVS_READ))
    else $error("read data moved outside a read answer");
  AST_RDATA_TOP: assert property (O_AVS_READDATA[31:16] == 16'h0)
    else $error("upper read data not zero");
  AST_IRQ_FALL: assert property
    ($fell(O_IRQ) |-> $past(ack) || $past(ack, 2))
    else $error("interrupt dropped without access");
  AST_IRQ_RISE: assert property
    ($rose(O_IRQ) |-> age_q <= 4'hc || $past(ack) || $past(ack, 2))
    else $error("interrupt raised without cause");
  AST_PIN_RELEASE: assert property
    ($past(I_RST, 2) && !$past(I_RST) |-> O_PIN_OE == $past(I_PORT_OE)
      && O_PIN_OUT == $past(I_PORT_OUT))
    else $error("pins not under port control after reset");
  AST_ACK_ONE: assert property (ack |=> !ack)
    else $error("answer longer than one cycle");
endmodule

// ==== steer_far_side.sv ====
// Far side model: PWM wave, period strobes, instruction tick, timers.
// Assumes it shares the clock and reset of the block.
`timescale 1ns/1ns
module steer_far_side (
  input wire i_clk,
  input wire i_rst,
  output wire [2:0] o_wave,
  output wire [2:0] o_period_end,
  output wire o_instr_tick,
  output wire [15:0] o_timer_a,
  output wire [15:0] o_timer_b
);
  reg [11:0] cnt_q;
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      cnt_q <= 12'h000;
    end else begin
      cnt_q <= cnt_q + 12'h001;
    end
  end
  assign o_timer_a = {4'h0, cnt_q};
  assign o_timer_b = {4'ha, cnt_q};
  // Eight cycle period, wave high for three
  assign o_wave = {3{cnt_q[2:0] < 3'h3}};
  assign o_period_end = {3{cnt_q[2:0] == 3'h7}};
  assign o_instr_tick = cnt_q[1:0] == 2'h2;
endmodule

// ==== test_capture_steer_top.sv ====
// Testbench for capture_steer_top: registers, capture and steering.
// Assumes the far side model supplies timers, waves and strobes.
`timescale 1ns/1ns
`include "capture_steer_defines.vh"
module test_capture_steer_top;
  reg clk = 1'b0;
  reg rst = 1'b1;
  reg [13:0] addr = 14'h0;
  reg rd_en = 1'b0;
  reg wr_en = 1'b0;
  reg [31:0] wdata = 32'h0;
  reg [2:0] cap = 3'h0;
  reg [11:0] port_out = 12'h5a5;
  reg [11:0] port_oe = 12'ha50;
  reg [31:0] rdata;
  reg wave_q = 1'b0;
  integer errors = 0;
  integer samples_checked = 0;
  integer cyc = 0;
  integer m;
  integer k;
  wire [31:0] avs_rdata;
  wire wreq, irq, tick;
  wire [2:0] wave, pend;
  wire [15:0] ta, tb;
  wire [11:0] pin_out, pin_oe;
  capture_steer_top capture_steer_top_inst (.I_REF_CLK(clk), .I_RST(rst),
    .I_CLK_EN(1'b1), .I_AVS_ADDRESS(addr), .I_AVS_READ(rd_en),
    .I_AVS_WRITE(wr_en), .I_AVS_WRITEDATA(wdata),
    .I_AVS_BYTEENABLE(4'h1), .O_AVS_READDATA(avs_rdata),
    .O_AVS_WAITREQUEST(wreq), .O_IRQ(irq), .I_CAPTURE_PIN(cap),
    .I_TIMER_A(ta), .I_TIMER_B(tb), .I_PWM_WAVE(wave),
    .I_PERIOD_END(pend), .I_INSTR_TICK(tick), .I_PORT_OUT(port_out),
    .I_PORT_OE(port_oe), .O_PIN_OUT(pin_out), .O_PIN_OE(pin_oe));
  steer_far_side steer_far_side_inst (.i_clk(clk), .i_rst(rst),
    .o_wave(wave), .o_period_end(pend), .o_instr_tick(tick),
    .o_timer_a(ta), .o_timer_b(tb));
  always #50 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    wave_q <= wave[0];
    if (cyc == 20000) begin
      errors = errors + 1;
      end_of_test;
    end
  end
  ////////////////////////////////////////////////////////////////////
  task end_of_test;
    begin
      $display("checks %0d errors %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0) begin
        $display("Finished cleanly");
      end else begin
        $display("Finished with errors");
      end
      $finish;
    end
  endtask
  task chk(input [31:0] seen, input [31:0] exp, input [63:0] what);
    begin
      samples_checked = samples_checked + 1;
      if (seen !== exp) begin
        errors = errors + 1;
        $display("mismatch %0s expected %h seen %h", what, exp, seen);
      end
    end
  endtask
  task acc(input [11:0] idx, input w, input [7:0] d);
    begin
      @(posedge clk);
      addr <= {idx, 2'b00};
      wdata <= {24'h0, d};
      wr_en <= w;
      rd_en <= !w;
      @(posedge clk);
      while (wreq !== 1'b0) @(posedge clk);
      rdata = avs_rdata;
      wr_en <= 1'b0;
      rd_en <= 1'b0;
    end
  endtask
  task rd(input [11:0] idx, input [31:0] exp, input [63:0] what);
    begin
      acc(idx, 1'b0, 8'h00);
      chk(rdata, exp, what);
    end
  endtask
  task pulse(input integer n);
    repeat (n) begin
      @(posedge clk);
      cap <= 3'h7;
      repeat (6) @(posedge clk);
      cap <= 3'h0;
      repeat (8) @(posedge clk);
    end
  endtask
  ////////////////////////////////////////////////////////////////////
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    rd(`IDX_STEER_1, 32'h01, "steer1");
    rd(`IDX_STEER_2, 32'h01, "steer2");
    rd(`IDX_STEER_3, 32'h01, "steer3");
    acc(`IDX_STEER_3, 1'b1, 8'hff);
    rd(`IDX_STEER_3, 32'hdf, "bit5");
    rd(12'h0ff, 32'h0, "unmapped");
    rd(`IDX_CTRL_1, 32'h0, "ctrl1");
    acc(`IDX_MASK, 1'b1, 8'h01);
    for (m = 4; m < 8; m = m + 1) begin
      acc(`IDX_CTRL_1, 1'b1, 8'h00);
      acc(`IDX_TSEL, 1'b1, {7'h0, m[0]});
      acc(`IDX_CTRL_1, 1'b1, m[7:0]);
      acc(`IDX_STATUS, 1'b0, 8'h00);
      k = (m == 6) ? 4 : (m == 7) ? 16 : 1;
      pulse(k - 1);
      rd(`IDX_STATUS, 32'h0, "early");
      pulse(1);
      chk(irq, 1'b1, "irq");
      rd(`IDX_STATUS, 32'h1, "status");
      acc(`IDX_CAP_1, 1'b0, 8'h00);
      chk(rdata[15:12], m[0] ? 4'ha : 4'h0, "tbase");
      repeat (3) @(posedge clk);
      chk(irq, 1'b0, "irq_clr");
      pulse(2);
    end
    acc(`IDX_MASK, 1'b1, 8'h00);
    acc(`IDX_CTRL_1, 1'b1, 8'h00);
    acc(`IDX_CTRL_1, 1'b1, 8'h06);
    acc(`IDX_STATUS, 1'b0, 8'h00);
    pulse(2);
    acc(`IDX_CTRL_1, 1'b1, 8'h07);
    repeat (3) @(posedge clk);
    chk(irq, 1'b0, "irq_mask");
    rd(`IDX_STATUS, 32'h1, "swap");
    pulse(13);
    rd(`IDX_STATUS, 32'h0, "kept");
    pulse(1);
    rd(`IDX_STATUS, 32'h1, "kept16");
    acc(`IDX_CTRL_1, 1'b1, 8'h0e);
    acc(`IDX_STEER_1, 1'b1, 8'h05);
    repeat (6) @(posedge clk);
    chk(pin_oe[3:0], 4'h5, "oe_ac");
    chk(pin_oe[11:4], port_oe[11:4], "oe_rest");
    for (k = 0; k < 8; k = k + 1) begin
      @(posedge clk);
      chk(pin_out[0], !wave_q, "pol_a");
    end
    while (pend[0] !== 1'b1) @(posedge clk);
    acc(`IDX_STEER_1, 1'b1, 8'h12);
    chk(pin_oe[3:0], 4'h5, "sync_old");
    while (pend[0] !== 1'b1) @(posedge clk);
    repeat (2) @(posedge clk);
    chk(pin_oe[3:0], 4'h2, "sync_new");
    acc(`IDX_STEER_1, 1'b1, 8'h40);
    repeat (12) @(posedge clk);
    k = pin_oe[1:0];
    repeat (8) @(posedge clk);
    chk(pin_oe[1:0] ^ k[1:0], 2'h3, "toggle");
    chk(^k[1:0], 1'b1, "one_pin");
    acc(`IDX_CTRL_1, 1'b1, 8'h4c);
    repeat (6) @(posedge clk);
    chk(pin_oe[3:0], port_oe[3:0], "pxm_oe");
    chk(pin_out[3:0], port_out[3:0], "pxm_out");
    end_of_test;
  end
endmodule
bind capture_steer_top capture_steer_properties #(.UNITS(UNITS))
  capture_steer_properties_inst (.*);
